// ==== rtl/ebc_ctrl.sv ====
// external bus control and arbitration: strobes, row strobes, wait states, bus request
//
// Functional notes
// - four row strobes, tri-statable, polarity chosen per line by software
// - read strobe driven low while master to read; driven high while master otherwise, tri-stated as slave
// - write strobe driven low while master to write; driven high while master otherwise, tri-stated as slave
// - transfer acknowledge ignored unless master with an external cycle running
// - each cycle with acknowledge deasserted adds one more wait state; the code does not do this for row strobe accesses or a zero minimum
// - cycle ends one output clock period after acknowledge is sampled asserted
// - wait states are the larger of acknowledge timing and programmed minimum; with a zero minimum or a row strobe access the code uses the minimum alone
// - acknowledge synchronous or asynchronous per mode register select bit
// - bus request asserted when mastership needed, dropped when not
// - bus request independent of role; parking keeps mastership without request
// - request hold bit keeps bus request asserted under software control
// - bus request only for external bus requests, never internal ones
// - hardware reset deasserts bus request and returns to bus slave
// - take mastership only after bus busy deasserts, then assert it
`timescale 1ns/10ps
module ebc_ctrl
  import ebc_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // register port
  input  wire logic [AW-1:0]      reg_addr,
  input  wire logic [DW-1:0]      reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [DW-1:0]      reg_rdata,
  // external access requests from the core
  input  wire logic               acc_req,
  input  wire logic               acc_we,
  input  wire logic               acc_dram,
  input  wire logic [1:0]         acc_ras_sel,
  input  wire logic               stop_wait,
  output logic                    acc_done,
  // strobe pins
  output logic                    rd_n_o,
  output logic                    wr_n_o,
  output logic                    strobe_oe,
  output logic      [NUM_RAS-1:0] ras_o,
  output logic                    ras_oe,
  // arbitration and acknowledge pins
  input  wire logic               transfer_ack_n,
  input  wire logic               bus_grant_n,
  input  wire logic               bus_busy_n_i,
  output logic                    bus_busy_n_o,
  output logic                    bus_busy_oe,
  output logic                    bus_request_n
);

  // whole state of the block
  typedef struct packed {
    bus_st_t            st;
    logic [WS_W-1:0]    cnt;
    logic               master;
    logic               br_n;
    logic               rd_n;
    logic               wr_n;
    logic               soe;
    logic [NUM_RAS-1:0] ras;
    logic               bb_o;
    logic               bb_oe;
    logic [WS_W-1:0]    ws_min;
    logic               hold;
    logic               ack_sync_select_bit;
    logic [NUM_RAS-1:0] pol;
    logic               ack_prev;
    logic               done;
    logic               dram;
    logic [DW-1:0]      rdata;
  } ctrl_t;

  ctrl_t s_q;
  ctrl_t s_d;

  logic       ack_s_n;
  logic       grant_s_n;
  logic       busy_s_n;
  logic       ack_ok;
  logic       ws_met;
  logic       fin_cond;
  logic       start;
  logic       grant;

  // pin inputs come from other clocks, so all three pass the synchroniser
  ebc_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({transfer_ack_n, bus_grant_n, bus_busy_n_i}),
    .q    ({ack_s_n, grant_s_n, busy_s_n})
  );

  assign grant = ~grant_s_n;

  // acknowledge qualification; async mode wants two agreeing samples
  assign ack_ok = ~ack_s_n & (~s_q.ack_prev | ~s_q.ack_sync_select_bit);

  // end of cycle: minimum met, and acknowledge seen unless it cannot stretch
  always_comb begin
    ws_met   = (s_q.cnt >= s_q.ws_min);
    fin_cond = (s_q.st == S_ACC) && s_q.master && ws_met &&
               ((s_q.ws_min == '0) || s_q.dram || ack_ok);
  end

  // no new access while stopped or while done stands: a request dropped on done is not retaken
  always_comb begin
    start = 1'b0;
    if (acc_req && !stop_wait && !s_q.done) begin
      if (s_q.st == S_IDLE) begin
        start = s_q.master && grant;                   // parked, no rearbitration
      end else if (s_q.st == S_ARB) begin
        start = grant && busy_s_n;
      end
    end
  end

  // next state
  always_comb begin
    s_d          = s_q;
    s_d.done     = 1'b0;
    s_d.ack_prev = ack_s_n;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        REG_BCR: begin
          s_d.ws_min = reg_wdata[BCR_WS_LSB +: WS_W];
          s_d.hold   = reg_wdata[BCR_HOLD_BIT];
        end
        REG_MODE: begin
          s_d.ack_sync_select_bit = reg_wdata[MODE_TAS_BIT];
          s_d.pol = reg_wdata[MODE_POL_LSB +: NUM_RAS];
        end
        default: ;
      endcase
    end

    // register reads, answered one cycle later; unmapped reads zero
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_BCR: begin
          s_d.rdata[BCR_WS_LSB +: WS_W] = s_q.ws_min;
          s_d.rdata[BCR_HOLD_BIT]       = s_q.hold;
        end
        REG_MODE: begin
          s_d.rdata[MODE_TAS_BIT]             = s_q.ack_sync_select_bit;
          s_d.rdata[MODE_POL_LSB +: NUM_RAS]  = s_q.pol;
        end
        REG_STAT: begin
          s_d.rdata[STAT_MASTER_BIT] = s_q.master;
          s_d.rdata[STAT_REQ_BIT]    = ~s_q.br_n;
          s_d.rdata[STAT_CYC_BIT]    = (s_q.st == S_ACC) || (s_q.st == S_FIN);
          s_d.rdata[STAT_BUSY_BIT]   = ~busy_s_n;
        end
        default: ;
      endcase
    end

    // arbitration and bus cycle sequencing
    case (s_q.st)
      S_IDLE: begin
        if (s_q.master && !grant) begin
          // grant withdrawn: active pull-up, drive busy high for one cycle
          s_d.st    = S_REL;
          s_d.bb_o  = 1'b1;
          s_d.bb_oe = 1'b1;
        end else if (acc_req && !stop_wait && !s_q.master) begin
          s_d.st = S_ARB;
        end
      end
      S_ARB: begin
        if (!acc_req) begin
          s_d.st = S_IDLE;
        end else if (grant && busy_s_n) begin
          s_d.master = 1'b1;
          s_d.soe    = 1'b1;
          s_d.bb_o   = 1'b0;
          s_d.bb_oe  = 1'b1;
        end
      end
      S_ACC: begin
        if (s_q.cnt != '1) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
        if (fin_cond) begin
          s_d.st = S_FIN;
        end
      end
      S_FIN: begin
        // strobes held one output clock beyond acceptance, then removed
        s_d.rd_n = 1'b1;
        s_d.wr_n = 1'b1;
        s_d.ras  = ~s_q.pol;
        s_d.done = 1'b1;
        s_d.st   = S_IDLE;
      end
      S_REL: begin
        // release busy and every strobe pin, back to slave
        s_d.bb_oe  = 1'b0;
        s_d.master = 1'b0;
        s_d.soe    = 1'b0;
        s_d.st     = S_IDLE;
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase

    // open an access: exactly one of the two strobes goes low
    if (start) begin
      s_d.st   = S_ACC;
      s_d.cnt  = '0;
      s_d.dram = acc_dram;
      s_d.rd_n = acc_we;
      s_d.wr_n = ~acc_we;
      s_d.ras  = ~s_q.pol;
      if (acc_dram) begin
        s_d.ras[acc_ras_sel] = s_q.pol[acc_ras_sel];
      end
    end

    // polarity changes reach idle row strobes at once
    if (!start && (s_q.st != S_ACC) && (s_q.st != S_FIN)) begin
      s_d.ras = ~s_d.pol;
    end

    // bus request follows external need or the hold bit, from core requests only
    if (stop_wait) begin
      s_d.br_n = s_q.hold ? s_q.br_n : 1'b1;
    end else begin
      s_d.br_n = ~(acc_req | s_q.hold);
    end
  end

  // reset lands in slave state with request deasserted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: S_IDLE, cnt: '0, master: 1'b0, br_n: 1'b1,
               rd_n: 1'b1, wr_n: 1'b1, soe: 1'b0, ras: ~POL_RST,
               bb_o: 1'b1, bb_oe: 1'b0, ws_min: WS_RST, hold: HOLD_RST,
               ack_sync_select_bit: TAS_RST, pol: POL_RST, ack_prev: 1'b1, done: 1'b0,
               dram: 1'b0, rdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register
  assign reg_rdata     = s_q.rdata;
  assign acc_done      = s_q.done;
  assign rd_n_o        = s_q.rd_n;
  assign wr_n_o        = s_q.wr_n;
  assign strobe_oe     = s_q.soe;
  assign ras_o         = s_q.ras;
  assign ras_oe        = s_q.soe;
  assign bus_busy_n_o  = s_q.bb_o;
  assign bus_busy_oe   = s_q.bb_oe;
  assign bus_request_n = s_q.br_n;

  // checks on the block's own behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence q_accept;
    (s_q.st == S_ACC) && fin_cond;
  endsequence

  sequence q_finish;
    (s_q.st == S_FIN) ##1 (s_q.rd_n && s_q.wr_n && s_q.done);
  endsequence

  property p_no_both_strobes;
    !(!s_q.rd_n && !s_q.wr_n);
  endproperty
  a_no_both_strobes: assert property (p_no_both_strobes)
    else $error("read and write strobes low together");

  property p_rd_only_master;
    !s_q.rd_n |-> (s_q.master && s_q.soe);
  endproperty
  a_rd_only_master: assert property (p_rd_only_master)
    else $error("read strobe low while not master");

  property p_wr_only_master;
    !s_q.master |-> (!s_q.soe && s_q.wr_n);
  endproperty
  a_wr_only_master: assert property (p_wr_only_master)
    else $error("write strobe driven while not master");

  property p_ras_pol;
    (s_q.st == S_IDLE) && !start |=> (s_q.ras == ~s_q.pol) || (s_q.st == S_ACC);
  endproperty
  a_ras_pol: assert property (p_ras_pol)
    else $error("idle row strobe not at inactive polarity");

  property p_ack_ignored;
    (s_q.st != S_ACC) |=> (s_q.st != S_FIN);
  endproperty
  a_ack_ignored: assert property (p_ack_ignored)
    else $error("cycle ended outside an external access");

  property p_stretch;
    (s_q.st == S_ACC) && !ack_ok && !s_q.dram && (s_q.ws_min != '0)
      |=> (s_q.st == S_ACC) && !s_q.done;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("cycle ended without acknowledge");

  property p_finish_timing;
    q_accept |=> q_finish;
  endproperty
  a_finish_timing: assert property (p_finish_timing)
    else $error("cycle did not end one clock after acceptance");

  property p_min_wait;
    (s_q.st == S_FIN) |-> ($past(s_q.cnt) >= s_q.ws_min) || $past(reg_wr);
  endproperty
  a_min_wait: assert property (p_min_wait)
    else $error("cycle shorter than programmed wait states");

  property p_async_ack;
    (s_q.st == S_ACC) && s_q.ack_sync_select_bit && ack_s_n |=> !ack_ok;
  endproperty
  a_async_ack: assert property (p_async_ack)
    else $error("async acknowledge taken on one sample");

  property p_request;
    !stop_wait && (acc_req || s_q.hold) |=> !s_q.br_n;
  endproperty
  a_request: assert property (p_request)
    else $error("bus request not asserted when needed");

  property p_release_request;
    !stop_wait && !acc_req && !s_q.hold |=> s_q.br_n;
  endproperty
  a_release_request: assert property (p_release_request)
    else $error("bus request held without need");

  property p_stop_hold;
    stop_wait |=> (s_q.br_n == ($past(s_q.hold) ? $past(s_q.br_n) : 1'b1));
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("bus request wrong during stop or wait");

  property p_reset_slave;
    $past(rst) |-> (s_q.br_n && !s_q.master && (s_q.st == S_IDLE));
  endproperty
  a_reset_slave: assert property (p_reset_slave)
    else $error("not slave with request off after reset");

  property p_take_bus;
    $rose(s_q.master) |-> $past(busy_s_n) && $past(grant) && s_q.bb_oe && !s_q.bb_o;
  endproperty
  a_take_bus: assert property (p_take_bus)
    else $error("mastership taken while bus busy");

endmodule : ebc_ctrl

// ==== rtl/ebc_pkg.sv ====
// constants, register layout and state type for the external bus control block
package ebc_pkg;

  // register port geometry
  localparam int DW      = 24;
  localparam int AW      = 4;
  localparam int NUM_RAS = 4;
  localparam int WS_W    = 4;

  // register indices on the plain register port
  localparam logic [AW-1:0] REG_BCR  = 4'h0;
  localparam logic [AW-1:0] REG_MODE = 4'h1;
  localparam logic [AW-1:0] REG_STAT = 4'h2;

  // bus_control_register fields
  localparam int BCR_WS_LSB   = 0;
  localparam int BCR_HOLD_BIT = 4;

  // operating mode register fields
  localparam int MODE_TAS_BIT = 0;
  localparam int MODE_POL_LSB = 4;

  // status register fields
  localparam int STAT_MASTER_BIT = 0;
  localparam int STAT_REQ_BIT    = 1;
  localparam int STAT_CYC_BIT    = 2;
  localparam int STAT_BUSY_BIT   = 3;

  // reset values
  localparam logic [WS_W-1:0]    WS_RST   = 4'h1;
  localparam logic               HOLD_RST = 1'h0;
  localparam logic               TAS_RST  = 1'h0;
  localparam logic [NUM_RAS-1:0] POL_RST  = 4'h0;

  // timing: cycle end follows one output clock period after acceptance
  localparam int MCLK_PS     = 5000;
  localparam int OUTCLK_PS   = 5000;
  localparam int FINISH_CYC  = (OUTCLK_PS + MCLK_PS - 1) / MCLK_PS;

  // arbitration and bus cycle states
  typedef enum logic [2:0] {
    S_IDLE,
    S_ARB,
    S_ACC,
    S_FIN,
    S_REL
  } bus_st_t;

endpackage : ebc_pkg

// ==== rtl/ebc_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ebc_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d    = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;

endmodule : ebc_sync

// ==== verif/ebc_far.sv ====
// far side model: memory acknowledge, bus arbiter, other master and busy pull-up
`timescale 1ns/10ps
module ebc_far (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // device pins
  input  wire logic rd_n_o,
  input  wire logic wr_n_o,
  input  wire logic strobe_oe,
  input  wire logic bus_busy_n_o,
  input  wire logic bus_busy_oe,
  input  wire logic bus_request_n,
  output logic      transfer_ack_n,
  output logic      bus_grant_n,
  output logic      busy_wire_n,
  // scenario control
  input  wire logic dram,
  input  wire logic other_master,
  input  wire logic [31:0] ack_delay
);
  int wait_q;

  // pull-up unless driven; the other master waits for the device to let go
  assign busy_wire_n = bus_busy_oe ? bus_busy_n_o : !(other_master && !strobe_oe);

  // arbiter parks the grant; acknowledge comes late on purpose to stretch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_grant_n    <= 1'b1;
      transfer_ack_n <= 1'b1;
      wait_q         <= 0;
    end else begin
      if (other_master)
        bus_grant_n <= 1'b1;
      else if (!bus_request_n)
        bus_grant_n <= 1'b0;
      // never acknowledges row strobe accesses; off again once the strobe ends
      if (strobe_oe && !(rd_n_o && wr_n_o) && !dram) begin
        wait_q         <= wait_q + 1;
        transfer_ack_n <= !(wait_q >= ack_delay);
      end else begin
        wait_q         <= 0;
        transfer_ack_n <= 1'b1;
      end
    end
  end
endmodule : ebc_far

// ==== verif/tb_ebc_ctrl.sv ====
// self-checking bench for the external bus control block
`timescale 1ns/10ps
module tb_ebc_ctrl
  import ebc_pkg::*;
;
  logic               mclk = 1'b0, rst = 1'b1;
  logic [AW-1:0]      reg_addr = '0;
  logic [DW-1:0]      reg_wdata = '0, reg_rdata, exp_q[$];
  logic               reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0;
  logic               acc_req = 1'b0, acc_we = 1'b0, acc_dram = 1'b0, stop_wait = 1'b0;
  logic [1:0]         acc_ras_sel = '0;
  logic               acc_done, rd_n_o, wr_n_o, strobe_oe, ras_oe;
  logic               bus_busy_n_o, bus_busy_oe, bus_request_n;
  logic [NUM_RAS-1:0] ras_o, pol = '0;
  logic               transfer_ack_n, bus_grant_n, busy_wire_n, other_master = 1'b0;
  logic               saw_rd = 1'b0, saw_wr = 1'b0, saw_both = 1'b0, saw_ras = 1'b0;
  int                 ack_delay = 0, failures = 0, compares = 0, low_cnt = 0, min_len = 0;

  always #2.5 mclk = !mclk;

  ebc_ctrl dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
    .acc_we(acc_we), .acc_dram(acc_dram), .acc_ras_sel(acc_ras_sel), .stop_wait(stop_wait),
    .acc_done(acc_done), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .strobe_oe(strobe_oe),
    .ras_o(ras_o), .ras_oe(ras_oe), .transfer_ack_n(transfer_ack_n),
    .bus_grant_n(bus_grant_n), .bus_busy_n_i(busy_wire_n), .bus_busy_n_o(bus_busy_n_o),
    .bus_busy_oe(bus_busy_oe), .bus_request_n(bus_request_n));

  ebc_far far (.mclk(mclk), .rst(rst), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
    .strobe_oe(strobe_oe), .bus_busy_n_o(bus_busy_n_o), .bus_busy_oe(bus_busy_oe),
    .bus_request_n(bus_request_n), .transfer_ack_n(transfer_ack_n),
    .bus_grant_n(bus_grant_n), .busy_wire_n(busy_wire_n), .dram(acc_dram),
    .other_master(other_master), .ack_delay(ack_delay));

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("counts: compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // strobes end with a gap cycle so no signal is assigned twice in one step
  task automatic reg_write(input logic [AW-1:0] a, input logic [DW-1:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : reg_write

  task automatic reg_read(input logic [AW-1:0] a, input logic [DW-1:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask : reg_read

  // one access; contend keeps another master on the bus for a while first
  task automatic access(input logic we, dram, contend, input int ws, d);
    int i;
    ack_delay <= d;
    min_len = dram ? ws + 2 : ((d > ws) ? d : ws) + 2;
    exp_q.push_back(DW'({dram, 1'b0, we, !we, 1'b1}));
    acc_we      <= we;
    acc_dram    <= dram;
    acc_ras_sel <= 2'($urandom);
    acc_req     <= 1'b1;
    if (contend) begin
      repeat (8) @(posedge mclk);
      check(DW'(bus_request_n), '0);
      check(DW'(strobe_oe), '0);
      other_master <= 1'b0;
    end
    for (i = 0; i < 300 && acc_done !== 1'b1; i++)
      @(posedge mclk);
    if (acc_done !== 1'b1) begin
      failures++;
      end_sim();
    end
    acc_req <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : access

  // read data stand one cycle after the strobe; accesses report at acc_done
  always @(posedge mclk) begin
    rd_pend <= reg_rd;
    if (rd_pend)
      check(reg_rdata, exp_q.pop_front());
    if (acc_req) begin
      saw_rd   <= saw_rd | (strobe_oe & !rd_n_o);
      saw_wr   <= saw_wr | (strobe_oe & !wr_n_o);
      saw_both <= saw_both | (strobe_oe & !rd_n_o & !wr_n_o);
      saw_ras  <= saw_ras | (ras_oe & |(~(ras_o ^ pol)));
      low_cnt  <= low_cnt + int'(!rd_n_o || !wr_n_o || (ras_oe && |(~(ras_o ^ pol))));
    end
    if (acc_done === 1'b1) begin
      check(DW'({saw_ras, saw_both, saw_wr, saw_rd, low_cnt >= min_len}),
            exp_q.pop_front());
      {saw_rd, saw_wr, saw_both, saw_ras} <= '0;
      low_cnt <= 0;
    end
  end

  initial begin
    int k, ws, i;
    void'($urandom(77));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    reg_read(REG_BCR, DW'(WS_RST) | (DW'(HOLD_RST) << BCR_HOLD_BIT));
    reg_read(REG_MODE, DW'(TAS_RST) | (DW'(POL_RST) << MODE_POL_LSB));
    reg_write(AW'(3 + $urandom % 13), 24'hFFFFFF);
    reg_read(AW'(3 + $urandom % 13), '0);
    $display("test reset values done");
    // both directions, both acknowledge modes, row strobe accesses last
    for (k = 0; k < 8; k++) begin
      ws  = 1 + $urandom % 3;
      pol = 4'($urandom);
      reg_write(REG_BCR, DW'(ws));
      reg_write(REG_MODE, (DW'(pol) << MODE_POL_LSB) | (DW'(k[1]) << MODE_TAS_BIT));
      reg_read(REG_BCR, DW'(ws));
      access(k[0], k[2] & k[1], 1'b0, ws, 4 + $urandom % 9);
    end
    check(DW'({strobe_oe, bus_request_n, bus_busy_oe, bus_busy_n_o}), DW'(4'b1110));
    reg_read(REG_STAT, (DW'(1) << STAT_MASTER_BIT) | (DW'(1) << STAT_BUSY_BIT));
    $display("test accesses done");
    // software hold, then stop or wait with and without it
    reg_write(REG_BCR, (DW'(1) << BCR_HOLD_BIT) | DW'(1));
    repeat (2) @(posedge mclk);
    check(DW'(bus_request_n), '0);
    stop_wait <= 1'b1;
    repeat (3) @(posedge mclk);
    check(DW'(bus_request_n), '0);
    reg_write(REG_BCR, DW'(1));
    repeat (2) @(posedge mclk);
    check(DW'(bus_request_n), DW'(1));
    stop_wait <= 1'b0;
    $display("test request hold done");
    // another master takes the bus; the device waits for busy to clear
    other_master <= 1'b1;
    for (i = 0; i < 50 && strobe_oe !== 1'b0; i++)
      @(posedge mclk);
    check(DW'(strobe_oe), '0);
    if (strobe_oe !== 1'b0)
      end_sim();
    access(1'b0, 1'b0, 1'b1, 1, 5);
    $display("test arbitration done");
    // reset in mid access drops the request and the mastership
    acc_req <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    check(DW'({strobe_oe, bus_request_n}), DW'(2'b01));
    acc_req <= 1'b0;
    rst     <= 1'b0;
    @(posedge mclk);
    reg_read(REG_BCR, DW'(WS_RST));
    $display("test second reset done");
    end_sim();
  end
endmodule : tb_ebc_ctrl
